// file: common/pcseq_consts.vh
// Constants of the purge cycle sequencer
`ifndef PCSEQ_CONSTS_VH
`define PCSEQ_CONSTS_VH
`define PCSEQ_CLK_HZ        100000000
`define PCSEQ_SEC_S         1
`define PCSEQ_SEC_CYC       (`PCSEQ_SEC_S * `PCSEQ_CLK_HZ)
`define PCSEQ_TICK_W        27
`define PCSEQ_MOVE_TMO_S    16'h0028
`define PCSEQ_AUTO_ZERO_S   16'h000a
`define PCSEQ_MIN_S         16'h003c
`define PCSEQ_TEMP_LIMIT    16'h0190
`define PCSEQ_ST_W          4
`define PCSEQ_ST_HOME       4'h0
`define PCSEQ_ST_GO_ZERO    4'h1
`define PCSEQ_ST_ZERO       4'h2
`define PCSEQ_ST_GO_CH1     4'h3
`define PCSEQ_ST_PURGE1     4'h4
`define PCSEQ_ST_GO_CH2     4'h5
`define PCSEQ_ST_PURGE2     4'h6
`define PCSEQ_ST_GO_HOME    4'h7
`define PCSEQ_ST_SETTLE     4'h8
`define PCSEQ_ST_FAULT      4'h9
`define PCSEQ_POS_HOME      2'h0
`define PCSEQ_POS_ZERO      2'h1
`define PCSEQ_POS_CH1       2'h2
`define PCSEQ_POS_CH2       2'h3
`endif

// file: src/pcseq_sync.v
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module pcseq_sync #(
    parameter W = 1
) (
    input  wire         clk_sys_i,
    input  wire         arst_n_i,
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
        end
    end
    assign q_o = s2_r;
endmodule // pcseq_sync

// file: src/pcseq_tick.v
// One-second tick generator
`timescale 1ns/1ns
`include "pcseq_consts.vh"
module pcseq_tick #(
    parameter [`PCSEQ_TICK_W-1:0] SEC_CYC = `PCSEQ_SEC_CYC
) (
    input  wire clk_sys_i,
    input  wire arst_n_i,
    output reg  tick_o
);
    reg [`PCSEQ_TICK_W-1:0] cnt_r;
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r  <= {`PCSEQ_TICK_W{1'b0}};
            tick_o <= 1'b0;
        end else if (cnt_r >= SEC_CYC - 1'b1) begin
            cnt_r  <= {`PCSEQ_TICK_W{1'b0}};
            tick_o <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule // pcseq_tick

// file: src/pcseq_top.v
// Purge cycle sequencer for an air purge unit
//
// What this block does
// - Fallback current on flow outputs when calculation fails
// - Collective alarm on any calculation error
// - Start only with valid temperature below 400
// - Home shows time to purge or waiting
// - Freeze dp, pressure, temperature inputs during cycle
// - Hold displayed values and outputs during cycle
// - Counters and pulse outputs keep last rate
// - Mirrored transmitter current held on first output
// - Start on timer expiry or external trigger
// - First move drives to zero-point position
// - Zero check 10 s auto, else configured
// - Move and purge chamber one, then two
// - After second purge drive back home
// - Settle configured time at home, then resume
// - Show move countdown against 40 s maximum
// - Move timeout flags destination-not-reached fault
// - Show remaining and configured time in dwells
// - Auto zero hides remaining time in check
// - Optional status signal during purge cycle
// - Timer minutes set interval between cycles
`timescale 1ns/1ns
`include "pcseq_consts.vh"
module pcseq_top #(
    parameter [`PCSEQ_TICK_W-1:0] SEC_CYC = `PCSEQ_SEC_CYC
) (
    input  wire        clk_sys_i,
    input  wire        arst_n_i,
    input  wire        unit_enable_i,
    input  wire        timer_on_i,
    input  wire [15:0] timer_min_i,
    input  wire        auto_zero_i,
    input  wire [15:0] zero_check_s_i,
    input  wire [15:0] purge_s_i,
    input  wire [15:0] settle_s_i,
    input  wire        status_en_i,
    input  wire        start_cmd_i,
    input  wire        fault_clr_i,
    input  wire        ext_trig_i,
    input  wire [1:0]  pos_fb_i,
    input  wire        pos_valid_i,
    input  wire        temp_valid_i,
    input  wire [15:0] temp_i,
    input  wire [15:0] dp_i,
    input  wire [15:0] press_i,
    input  wire [15:0] flow_rate_i,
    input  wire [15:0] aout_i,
    input  wire [15:0] fallback_i,
    input  wire        aout_is_flow_i,
    input  wire        aout_mirror_i,
    input  wire [15:0] tx_current_i,
    input  wire        calc_err_i,
    output reg         drive_on_o,
    output reg  [1:0]  drive_target_o,
    output reg  [3:0]  state_o,
    output reg         cycle_active_o,
    output reg         status_o,
    output reg         alarm_o,
    output reg         fault_o,
    output reg         wait_ext_o,
    output reg  [15:0] remain_s_o,
    output reg  [15:0] total_s_o,
    output reg         remain_show_o,
    output reg  [15:0] dp_o,
    output reg  [15:0] press_o,
    output reg  [15:0] temp_o,
    output reg  [15:0] rate_o,
    output reg  [15:0] aout_o,
    output reg  [31:0] total_o
);
    wire [3:0] pin_q;
    wire       trig_s;
    wire [1:0] pos_s;
    wire       pos_ok_s;
    wire       tick;
    reg        trig_d_r;
    reg [3:0]  st_r;
    reg [3:0]  st_nxt;
    reg [15:0] cnt_r;
    reg [15:0] cnt_nxt;
    reg [31:0] wait_r;
    reg        go;
    reg        start_ok;
    wire       trig_edge;
    wire       active;

    // Trigger and position feedback come from pins
    // Code and valid pass the same two stages, so a move is only
    // taken as done when both agree after synchronisation; a one-cycle
    // skew between them merely delays arrival by a clock
    pcseq_sync #(.W(4)) u_sync (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .d_i       ({ext_trig_i, pos_valid_i, pos_fb_i}),
        .q_o       (pin_q)
    );
    assign trig_s   = pin_q[3];
    assign pos_ok_s = pin_q[2];
    assign pos_s    = pin_q[1:0];

    pcseq_tick #(.SEC_CYC(SEC_CYC)) u_tick (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .tick_o    (tick)
    );

    function is_move;
        input [3:0] s;
        begin
            is_move = (s == `PCSEQ_ST_GO_ZERO) || (s == `PCSEQ_ST_GO_CH1) ||
                      (s == `PCSEQ_ST_GO_CH2) || (s == `PCSEQ_ST_GO_HOME);
        end
    endfunction

    function [1:0] target_of;
        input [3:0] s;
        begin
            case (s)
                `PCSEQ_ST_GO_ZERO: target_of = `PCSEQ_POS_ZERO;
                `PCSEQ_ST_GO_CH1:  target_of = `PCSEQ_POS_CH1;
                `PCSEQ_ST_GO_CH2:  target_of = `PCSEQ_POS_CH2;
                default:           target_of = `PCSEQ_POS_HOME;
            endcase
        end
    endfunction

    assign trig_edge = trig_s & ~trig_d_r;
    assign active    = (st_r != `PCSEQ_ST_HOME) && (st_r != `PCSEQ_ST_FAULT);

    // Interval in seconds; computed from timer_min_i even when timer off
    // Product is kept at full width so long intervals do not wrap;
    // the display shows only the low half, a known limitation
    wire [31:0] interval_s = timer_min_i * `PCSEQ_MIN_S;

    always @* begin
        go       = start_cmd_i | trig_edge | (timer_on_i && tick && wait_r == 32'h0000_0000);
        start_ok = temp_valid_i && (temp_i < `PCSEQ_TEMP_LIMIT);
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        if (is_move(st_r)) begin
            if (pos_ok_s && pos_s == target_of(st_r)) begin
                case (st_r)
                    `PCSEQ_ST_GO_ZERO: begin
                        st_nxt  = `PCSEQ_ST_ZERO;
                        cnt_nxt = auto_zero_i ? `PCSEQ_AUTO_ZERO_S : zero_check_s_i;
                    end
                    `PCSEQ_ST_GO_CH1: begin
                        st_nxt  = `PCSEQ_ST_PURGE1;
                        cnt_nxt = purge_s_i;
                    end
                    `PCSEQ_ST_GO_CH2: begin
                        st_nxt  = `PCSEQ_ST_PURGE2;
                        cnt_nxt = purge_s_i;
                    end
                    default: begin
                        st_nxt  = `PCSEQ_ST_SETTLE;
                        cnt_nxt = settle_s_i;
                    end
                endcase
            end else if (tick) begin
                if (cnt_r <= 16'h0001)
                    st_nxt = `PCSEQ_ST_FAULT;
                cnt_nxt = cnt_r - 16'h0001;
            end
        end else begin
            case (st_r)
                `PCSEQ_ST_HOME: begin
                    if (unit_enable_i && go && start_ok) begin
                        st_nxt  = `PCSEQ_ST_GO_ZERO;
                        cnt_nxt = `PCSEQ_MOVE_TMO_S;
                    end
                end
                `PCSEQ_ST_ZERO, `PCSEQ_ST_PURGE1, `PCSEQ_ST_PURGE2, `PCSEQ_ST_SETTLE: begin
                    if (cnt_r == 16'h0000 || (tick && cnt_r == 16'h0001)) begin
                        cnt_nxt = `PCSEQ_MOVE_TMO_S;
                        case (st_r)
                            `PCSEQ_ST_ZERO:   st_nxt = `PCSEQ_ST_GO_CH1;
                            `PCSEQ_ST_PURGE1: st_nxt = `PCSEQ_ST_GO_CH2;
                            `PCSEQ_ST_PURGE2: st_nxt = `PCSEQ_ST_GO_HOME;
                            default: begin
                                st_nxt  = `PCSEQ_ST_HOME;
                                cnt_nxt = 16'h0000;
                            end
                        endcase
                    end else if (tick) begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end
                end
                `PCSEQ_ST_FAULT: begin
                    if (fault_clr_i)
                        st_nxt = `PCSEQ_ST_HOME;
                end
                default: st_nxt = `PCSEQ_ST_HOME;
            endcase
        end
    end

    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r           <= `PCSEQ_ST_HOME;
            cnt_r          <= 16'h0000;
            wait_r         <= 32'h0000_0000;
            trig_d_r       <= 1'b0;
            drive_on_o     <= 1'b0;
            drive_target_o <= `PCSEQ_POS_HOME;
            state_o        <= `PCSEQ_ST_HOME;
            cycle_active_o <= 1'b0;
            status_o       <= 1'b0;
            alarm_o        <= 1'b0;
            fault_o        <= 1'b0;
            wait_ext_o     <= 1'b0;
            remain_s_o     <= 16'h0000;
            total_s_o      <= 16'h0000;
            remain_show_o  <= 1'b0;
            dp_o           <= 16'h0000;
            press_o        <= 16'h0000;
            temp_o         <= 16'h0000;
            rate_o         <= 16'h0000;
            aout_o         <= 16'h0000;
            total_o        <= 32'h0000_0000;
        end else begin
            st_r     <= st_nxt;
            cnt_r    <= cnt_nxt;
            trig_d_r <= trig_s;
            // Interval restarts after every cycle end and on any start attempt
            if (st_r != `PCSEQ_ST_HOME || go)
                wait_r <= interval_s;
            else if (tick && wait_r != 32'h0000_0000)
                wait_r <= wait_r - 32'h0000_0001;
            // Drive is cut as soon as the fault state is entered
            // Outputs follow the next state so drive and state never
            // disagree for a cycle at a move boundary
            drive_on_o     <= is_move(st_nxt);
            drive_target_o <= target_of(st_nxt);
            state_o        <= st_nxt;
            cycle_active_o <= active;
            status_o       <= status_en_i & active;
            fault_o        <= (st_nxt == `PCSEQ_ST_FAULT);
            alarm_o        <= calc_err_i;
            wait_ext_o     <= (st_r == `PCSEQ_ST_HOME) && !timer_on_i;
            // Time fields by state
            if (st_r == `PCSEQ_ST_HOME) begin
                remain_s_o    <= wait_r[15:0];
                total_s_o     <= interval_s[15:0];
                remain_show_o <= timer_on_i;
            end else if (is_move(st_r)) begin
                remain_s_o    <= cnt_r;
                total_s_o     <= `PCSEQ_MOVE_TMO_S;
                remain_show_o <= 1'b1;
            end else if (st_r == `PCSEQ_ST_FAULT) begin
                remain_s_o    <= 16'h0000;
                total_s_o     <= `PCSEQ_MOVE_TMO_S;
                remain_show_o <= 1'b0;
            end else begin
                remain_s_o <= cnt_r;
                case (st_r)
                    `PCSEQ_ST_ZERO:   total_s_o <= auto_zero_i ? `PCSEQ_AUTO_ZERO_S : zero_check_s_i;
                    `PCSEQ_ST_SETTLE: total_s_o <= settle_s_i;
                    default:          total_s_o <= purge_s_i;
                endcase
                remain_show_o <= !(st_r == `PCSEQ_ST_ZERO && auto_zero_i);
            end
            // Measured values only track outside the cycle
            if (!active) begin
                dp_o    <= dp_i;
                press_o <= press_i;
                temp_o  <= temp_i;
                rate_o  <= flow_rate_i;
                if (aout_mirror_i)
                    aout_o <= tx_current_i;
                else if (aout_is_flow_i && calc_err_i)
                    aout_o <= fallback_i;
                else
                    aout_o <= aout_i;
            end
            // Totaliser keeps counting at the held rate through a cycle
            if (tick)
                total_o <= total_o + {16'h0000, rate_o};
        end
    end
endmodule // pcseq_top

// file: verif/pcseq_top_asserts.sv
// Port checker of the purge cycle sequencer
`timescale 1ns/1ns
`include "pcseq_consts.vh"
module pcseq_chk (
    input wire        clk_sys_i, arst_n_i, unit_enable_i, timer_on_i, auto_zero_i, fault_clr_i,
    input wire        temp_valid_i, calc_err_i, aout_is_flow_i, aout_mirror_i,
    input wire        drive_on_o, fault_o, wait_ext_o, remain_show_o, alarm_o,
    input wire [1:0]  drive_target_o,
    input wire [3:0]  state_o,
    input wire [15:0] temp_i, fallback_i, dp_o, press_o, temp_o, rate_o, aout_o, total_s_o,
    input wire [31:0] total_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    wire busy = state_o != `PCSEQ_ST_HOME && state_o != `PCSEQ_ST_FAULT;
    wire no_go = !unit_enable_i || !temp_valid_i || temp_i >= `PCSEQ_TEMP_LIMIT;
    // Legal successions; a zero-length dwell still lasts one clock, so it shows as no skip here
    function automatic bit legal(input [3:0] a, input [3:0] b);
        legal = (b == a + 4'h1 && a < 4'h8) || (b == 4'h9 && a[0]) || (b == 4'h0 && (a == 4'h8 || a == 4'h9));
    endfunction
    property p_alarm; 1'b1 |=> alarm_o == $past(calc_err_i); endproperty
    a_alarm: assert property (p_alarm) else $error("alarm wrong");
    property p_fallback; aout_is_flow_i && calc_err_i && !aout_mirror_i && state_o == `PCSEQ_ST_HOME
        |=> aout_o == $past(fallback_i); endproperty
    a_fallback: assert property (p_fallback) else $error("no fallback");
    property p_freeze; busy && $past(busy) |-> $stable(dp_o) && $stable(press_o) && $stable(temp_o)
        && $stable(aout_o) && $stable(rate_o); endproperty
    a_freeze: assert property (p_freeze) else $error("value moved in cycle");
    property p_total; busy && $past(busy) && $changed(total_o) |-> total_o == $past(total_o) + {16'h0000, rate_o};
    endproperty
    a_total: assert property (p_total) else $error("totaliser rate wrong");
    property p_drive; drive_on_o |-> state_o[0] && !state_o[3] && drive_target_o == state_o[2:1] + 2'h1; endproperty
    a_drive: assert property (p_drive) else $error("drive target wrong");
    property p_tmo; drive_on_o && $past(drive_on_o) |-> total_s_o == `PCSEQ_MOVE_TMO_S; endproperty
    a_tmo: assert property (p_tmo) else $error("move limit wrong");
    property p_fault; fault_o |-> !drive_on_o && state_o == `PCSEQ_ST_FAULT; endproperty
    a_fault: assert property (p_fault) else $error("fault drive on");
    property p_hold; fault_o && !fault_clr_i |=> fault_o; endproperty
    a_hold: assert property (p_hold) else $error("fault left");
    property p_order; $changed(state_o) |-> legal($past(state_o), state_o); endproperty
    a_order: assert property (p_order) else $error("bad step");
    property p_refuse; state_o == `PCSEQ_ST_HOME && no_go |=> state_o == `PCSEQ_ST_HOME; endproperty
    a_refuse: assert property (p_refuse) else $error("refused start ran");
    property p_hide; state_o == `PCSEQ_ST_ZERO && $past(state_o) == `PCSEQ_ST_ZERO && auto_zero_i
        && $past(auto_zero_i) |-> !remain_show_o; endproperty
    a_hide: assert property (p_hide) else $error("time shown");
    c_settle: cover property (state_o == `PCSEQ_ST_SETTLE);
    c_fault: cover property (fault_o);
    c_wait: cover property (wait_ext_o);
endmodule // pcseq_chk

// file: verif/pcseq_drive_model.sv
// Rotary drive model with position feedback
`timescale 1ns/1ns
module pcseq_drive_model (
    input  wire       clk_sys_i,
    input  wire       arst_n_i,
    input  wire       drive_on_i,
    input  wire [1:0] target_i,
    input  wire [7:0] dly_i,
    input  wire       stall_i,
    output wire [1:0] pos_fb_o,
    output wire       pos_valid_o
);
    reg [1:0] pos_r;
    reg       ok_r;
    reg [7:0] cnt_r;
    // Code lines carry noise while moving, only valid qualifies them
    assign pos_fb_o = ok_r ? pos_r : cnt_r[1:0];
    assign pos_valid_o = ok_r;
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pos_r <= 2'h0;
            ok_r <= 1'b1;
            cnt_r <= 8'h00;
        end else if (drive_on_i && (!ok_r || pos_r != target_i)) begin
            ok_r <= 1'b0;
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r >= dly_i && !stall_i) begin
                pos_r <= target_i;
                ok_r <= 1'b1;
                cnt_r <= 8'h00;
            end
        end
    end
endmodule // pcseq_drive_model

// file: verif/purge_cycle_sequencer_bench.sv
// Testbench of the purge cycle sequencer
`timescale 1ns/1ns
`include "pcseq_consts.vh"
module purge_cycle_sequencer_bench;
    reg clk_sys_i, arst_n_i, unit_enable_i, timer_on_i, auto_zero_i, status_en_i, start_cmd_i, fault_clr_i;
    reg ext_trig_i, temp_valid_i, aout_is_flow_i, aout_mirror_i, calc_err_i, stall;
    reg [7:0] dly;
    reg [15:0] timer_min_i, zero_check_s_i, purge_s_i, settle_s_i, temp_i, dp_i, press_i;
    reg [15:0] flow_rate_i, aout_i, fallback_i, tx_current_i, d;
    wire pos_valid_i, drive_on_o, cycle_active_o, status_o, alarm_o, fault_o, wait_ext_o, remain_show_o;
    wire [1:0] pos_fb_i, drive_target_o;
    wire [3:0] state_o;
    wire [15:0] remain_s_o, total_s_o, dp_o, press_o, temp_o, rate_o, aout_o;
    wire [31:0] total_o;
    integer fails, samples_checked, waited;
    // One second is ten clocks so a whole cycle fits a short run
    pcseq_top #(.SEC_CYC(27'h000000a)) pcseq_top_inst (.*);
    pcseq_drive_model pcseq_drive_model_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .drive_on_i(drive_on_o),
        .target_i(drive_target_o), .dly_i(dly), .stall_i(stall), .pos_fb_o(pos_fb_i), .pos_valid_o(pos_valid_i));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task wrap_up;
        begin
            $display("fails=%0d samples_checked=%0d", fails, samples_checked);
            if (fails == 0 && samples_checked > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task tk(input integer n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task wait_st(input [3:0] s);
        begin
            waited = 0;
            while (state_o !== s && waited < 2000) begin
                tk(1);
                waited = waited + 1;
            end
            if (waited == 2000) begin
                fails = fails + 1;
                $display("BAD t=%0t state=%h exp=%h", $time, state_o, s);
                wrap_up;
            end
        end
    endtask
    task go;
        begin
            @(posedge clk_sys_i) start_cmd_i <= 1'b1;
            @(posedge clk_sys_i) start_cmd_i <= 1'b0;
        end
    endtask
    task t_full;
        begin
            d = dp_i;
            go;
            wait_st(4'h1);
            tk(2);
            chk(drive_on_o, 1);
            chk(status_o, 1);
            chk(remain_s_o > 16'h0026, 1);
            dp_i <= dp_i + 16'h0011;
            temp_i <= 16'h0123;
            wait_st(4'h2);
            tk(1);
            chk(dp_o, d);
            chk(temp_o, 16'h0050);
            chk(total_s_o, zero_check_s_i);
            wait_st(4'h4);
            tk(1);
            chk(total_s_o, purge_s_i);
            wait_st(4'h6);
            wait_st(4'h8);
            tk(1);
            chk(total_s_o, settle_s_i);
            wait_st(4'h0);
            tk(3);
            chk(dp_o, dp_i);
            chk(cycle_active_o, 0);
        end
    endtask
    task t_refuse;
        integer i;
        begin
            for (i = 0; i < 2; i = i + 1) begin
                @(posedge clk_sys_i) temp_valid_i <= i[0];
                temp_i <= i[0] ? `PCSEQ_TEMP_LIMIT : 16'h0010;
                go;
                tk(20);
                chk(state_o, `PCSEQ_ST_HOME);
            end
            temp_valid_i <= 1'b1;
            temp_i <= 16'h0050;
            tk(1);
        end
    endtask
    task t_timeout;
        begin
            stall <= 1'b1;
            go;
            wait_st(4'h1);
            wait_st(4'h9);
            chk(waited >= 390 && waited <= 410, 1);
            tk(2);
            chk(drive_on_o, 0);
            chk(fault_o, 1);
            stall <= 1'b0;
            fault_clr_i <= 1'b1;
            tk(2);
            fault_clr_i <= 1'b0;
            wait_st(4'h0);
        end
    endtask
    task t_ext;
        begin
            tk(3);
            chk(wait_ext_o, 1);
            auto_zero_i <= 1'b1;
            ext_trig_i <= 1'b1;
            tk(6);
            ext_trig_i <= 1'b0;
            wait_st(4'h2);
            tk(1);
            chk(total_s_o, `PCSEQ_AUTO_ZERO_S);
            chk(remain_show_o, 0);
            wait_st(4'h0);
            auto_zero_i <= 1'b0;
        end
    endtask
    task t_timer;
        begin
            timer_on_i <= 1'b1;
            timer_min_i <= 16'h0001;
            tk(3);
            chk(wait_ext_o, 0);
            chk(remain_show_o, 1);
            wait_st(4'h1);
            chk(waited <= 610, 1);
            timer_on_i <= 1'b0;
            wait_st(4'h0);
        end
    endtask
    task t_err;
        begin
            aout_is_flow_i <= 1'b1;
            calc_err_i <= 1'b1;
            tk(3);
            chk(alarm_o, 1);
            chk(aout_o, fallback_i);
            aout_mirror_i <= 1'b1;
            tk(3);
            chk(aout_o, tx_current_i);
            calc_err_i <= 1'b0;
            aout_mirror_i <= 1'b0;
            tk(3);
            chk(alarm_o, 0);
            chk(aout_o, aout_i);
        end
    endtask
    initial begin
        {arst_n_i, timer_on_i, auto_zero_i, start_cmd_i, fault_clr_i, ext_trig_i, stall} = 7'h00;
        {aout_is_flow_i, aout_mirror_i, calc_err_i} = 3'h0;
        {unit_enable_i, status_en_i, temp_valid_i} = 3'h7;
        {timer_min_i, zero_check_s_i, purge_s_i, settle_s_i} = {16'h0001, 16'h0002, 16'h0003, 16'h0002};
        {temp_i, dp_i, press_i, flow_rate_i} = {16'h0050, 16'h0200, 16'h0300, 16'h0007};
        {aout_i, fallback_i, tx_current_i, dly} = {16'h1234, 16'h0abc, 16'h5555, 8'h05};
        fails = 0;
        samples_checked = 0;
        tk(6);
        arst_n_i <= 1'b1;
        tk(4);
        t_refuse;
        t_full;
        t_err;
        t_timeout;
        t_ext;
        t_timer;
        wrap_up;
    end
endmodule // purge_cycle_sequencer_bench
bind pcseq_top pcseq_chk pcseq_chk_inst (.*);
